// *** verilog/axis_pkg.sv ***
// Shared types and constants for the axis homing and manual-motion sequencer.
package axis_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam logic [31:0] CLK_HZ_W = 32'(CLK_HZ);

    // ------------------------------------------------------------------
    // Speeds, directions and sensor positions
    // ------------------------------------------------------------------
    localparam int SPEED_W = 20;
    typedef logic [SPEED_W-1:0] speed_t;
    typedef logic [15:0] msec_t;

    // Speed limit in pulses per second; ramp times run from 0 up to it.
    localparam logic [31:0] SPEED_LIMIT = 32'h0001_86a0;

    localparam logic CLOCKWISE_DIRECTION = 1'b0;
    localparam logic COUNTER_CLOCKWISE_DIRECTION = 1'b1;

    localparam int SN_APPROACH = 0;
    localparam int SN_MARKER = 1;
    localparam int SN_INDEX = 2;
    localparam int SN_UPPER = 3;
    localparam int SN_LOWER = 4;
    localparam int SN_COUNT = 5;

    // ------------------------------------------------------------------
    // Modes and carriers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        HM_DOG_RELEASED,
        HM_DOG_HELD,
        HM_DOG_ONLY,
        HM_LIMIT_MARKER,
        HM_LIMIT_ONLY
    } home_method_t;

    typedef struct packed {
        home_method_t method;
        logic home_dir;
        logic marker_is_index;
        logic signed [31:0] home_addr;
        speed_t home_high;
        speed_t home_low;
        logic signed [31:0] home_comp;
        msec_t home_acc_ms;
        msec_t home_dec_ms;
        msec_t dwell_ms;
        speed_t jog_high;
        speed_t jog_low;
        msec_t jog_acc_ms;
        msec_t jog_dec_ms;
        speed_t inch_speed;
    } axis_cfg_t;

    typedef struct packed {
        speed_t target;
        msec_t acc_ms;
        msec_t dec_ms;
    } ramp_cmd_t;

    typedef struct packed {
        logic busy;
        logic homed;
        logic home_error;
        logic pos_done;
        logic cmd_rejected;
    } axis_status_t;

    // Parameter set as delivered before software changes it.
    localparam axis_cfg_t CFG_DEFAULT = '{
        method: HM_DOG_RELEASED,
        home_dir: COUNTER_CLOCKWISE_DIRECTION,
        marker_is_index: 1'b0,
        home_addr: 32'sh0000_0000,
        home_high: 20'h0_1388,
        home_low: 20'h0_01f4,
        home_comp: 32'sh0000_0000,
        home_acc_ms: 16'h03e8,
        home_dec_ms: 16'h03e8,
        dwell_ms: 16'h0000,
        jog_high: 20'h0_1388,
        jog_low: 20'h0_03e8,
        jog_acc_ms: 16'h03e8,
        jog_dec_ms: 16'h03e8,
        inch_speed: 20'h0_0064
    };

endpackage

// *** verilog/motion_ramp.sv ***
// Speed ramp and pulse-train generator for one axis.
`timescale 1ns/10ps
module motion_ramp #(
    parameter int MS_CYCLES = axis_pkg::CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire axis_pkg::ramp_cmd_t cmd,
    input wire logic halt,
    output logic step,
    output axis_pkg::speed_t speed,
    output logic at_speed,
    output logic stopped
);
    import axis_pkg::*;

    logic [31:0] ramp_acc;
    logic [31:0] phase;
    logic [31:0] thr;
    logic [31:0] next_acc;
    logic [31:0] next_phase;
    logic [31:0] delta;

    // Ramp time in cycles; a zero time is taken as one millisecond.
    function automatic logic [31:0] ramp_cycles(input msec_t ms);
        msec_t eff;
        eff = (ms == 16'h0000) ? 16'h0001 : ms;
        return 32'(eff) * 32'(MS_CYCLES);
    endfunction

    always_comb begin
        thr = (speed > cmd.target) ? ramp_cycles(cmd.dec_ms)
                                   : ramp_cycles(cmd.acc_ms);
        next_acc = ramp_acc + SPEED_LIMIT;
        delta = next_acc / thr;
        next_phase = phase + 32'(speed);
    end

    assign at_speed = (speed == cmd.target);
    assign stopped = (speed == '0);

    // ------------------------------------------------------------------
    // Speed ramp
    // ------------------------------------------------------------------
    // The slope reaches the speed limit in the ramp time.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            speed <= '0;
            ramp_acc <= 32'h0000_0000;
        end else if (ce) begin
            if (halt) begin
                speed <= '0;
                ramp_acc <= 32'h0000_0000;
            end else if (speed == cmd.target) begin
                ramp_acc <= 32'h0000_0000;
            end else if (next_acc >= thr) begin
                ramp_acc <= next_acc % thr;
                if (speed > cmd.target) begin
                    speed <= (32'(speed - cmd.target) > delta)
                             ? speed - speed_t'(delta) : cmd.target;
                end else begin
                    speed <= (32'(cmd.target - speed) > delta)
                             ? speed + speed_t'(delta) : cmd.target;
                end
            end else begin
                ramp_acc <= next_acc;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase <= 32'h0000_0000;
            step <= 1'b0;
        end else if (ce) begin
            if (next_phase >= CLK_HZ_W) begin
                phase <= next_phase - CLK_HZ_W;
                step <= 1'b1;
            end else begin
                phase <= next_phase;
                step <= 1'b0;
            end
        end
    end

endmodule

// *** verilog/axis_homing_jog_sequencer.sv ***
// Homing, jog and inching sequencer for one pulse-driven axis.
//
// Summary of operation
// - Homing seeks in home direction at home high speed, homing ramps.
// - Approach slows to low speed; marker then stops and loads home.
// - Released method: marker while slowing or approach on gives no home.
// - Held method: marker with approach off gives no home.
// - Index as marker is ignored at high speed or slowing.
// - Limit before approach: sudden stop, reverse at same speed.
// - Limits during seek and creep stop at once, no deceleration ramp; compensation ignores them.
// - After limit reversal, first approach stops and reverses.
// - Approach only: home at third approach edge, last leg slow.
// - Limit then marker: sudden stop, reverse slowly, home on marker.
// - Limit only: reverse slowly until limit releases, home there.
// - Compensation moves at low speed before the home address loads.
// - Completion rises after the last pulse and the dwell time.
// - Jog speed is high or low by the select bit at start.
// - Jog counts position only once homed.
// - Jog ramps with jog acceleration and deceleration times.
// - Inching moves a distance at inching speed; unhomed keeps position.
`timescale 1ns/10ps
module axis_homing_jog_sequencer #(
    parameter int MS_CYCLES = axis_pkg::CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire axis_pkg::axis_cfg_t cfg,
    input wire logic home_start,
    input wire logic jog_start,
    input wire logic jog_high_sel,
    input wire logic jog_dir,
    input wire logic jog_stop,
    input wire logic inch_start,
    input wire logic inch_dir,
    input wire logic [31:0] inch_distance,
    input wire logic approach,
    input wire logic marker,
    input wire logic enc_index,
    input wire logic upper_limit,
    input wire logic lower_limit,
    output logic step_pulse,
    output logic step_dir,
    output logic signed [31:0] position,
    output axis_pkg::axis_status_t status
);
    import axis_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SEEK,
        S_STOP,
        S_CREEP,
        S_COMP,
        S_JOG,
        S_INCH,
        S_DWELL
    } state_t;

    typedef enum logic [2:0] {
        AF_REV_FAST,
        AF_REV_SLOW,
        AF_HOME,
        AF_SET,
        AF_ERROR,
        AF_DONE,
        AF_IDLE
    } after_t;

    state_t state;
    after_t after;
    logic dir;
    logic reversed;
    logic dog_hits;
    logic jog_fast;
    logic halt;
    logic homed;
    logic home_error;
    logic pos_done;
    logic cmd_rejected;
    logic [31:0] remain;
    logic [31:0] dwell_cnt;
    logic [31:0] dwell_target;
    msec_t rc_acc;
    msec_t rc_dec;
    ramp_cmd_t rcmd;
    speed_t speed;
    logic at_speed;
    logic stopped;
    logic [SN_COUNT-1:0] pins;
    logic [SN_COUNT-1:0] s1;
    logic [SN_COUNT-1:0] s2;
    logic [SN_COUNT-1:0] s3;
    logic [SN_COUNT-1:0] sens;
    logic [SN_COUNT-1:0] sens_prev;
    logic [SN_COUNT-1:0] rise;
    logic ahead_limit;
    logic back_fall;
    logic marker_ev;
    logic limit_method;
    logic creep_hit;
    logic creep_ok;
    logic home_load;
    logic any_start;

    function automatic logic [31:0] magnitude(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ------------------------------------------------------------------
    // Sensor input conditioning
    // ------------------------------------------------------------------
    assign pins = {lower_limit, upper_limit, enc_index, marker, approach};

    // A level is taken once the second and third stages agree.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sens <= '0;
            sens_prev <= '0;
        end else if (ce) begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            sens <= (s2 & s3) | (sens & (s2 | s3));
            sens_prev <= sens;
        end
    end

    assign rise = sens & ~sens_prev;
    assign ahead_limit = (dir == COUNTER_CLOCKWISE_DIRECTION)
                         ? sens[SN_LOWER] : sens[SN_UPPER];
    assign back_fall = (dir == COUNTER_CLOCKWISE_DIRECTION)
                       ? (sens_prev[SN_UPPER] & ~sens[SN_UPPER])
                       : (sens_prev[SN_LOWER] & ~sens[SN_LOWER]);
    assign marker_ev = cfg.marker_is_index ? rise[SN_INDEX] : rise[SN_MARKER];
    assign limit_method = (cfg.method == HM_LIMIT_MARKER) ||
                          (cfg.method == HM_LIMIT_ONLY);
    assign any_start = home_start | jog_start | inch_start;

    // ------------------------------------------------------------------
    // Home detection at low speed
    // ------------------------------------------------------------------
    always_comb begin
        unique case (cfg.method)
            HM_DOG_RELEASED: begin
                creep_hit = marker_ev &&
                            (at_speed || !cfg.marker_is_index);
                creep_ok = at_speed && !sens[SN_APPROACH];
            end
            HM_DOG_HELD: begin
                creep_hit = marker_ev && at_speed;
                creep_ok = sens[SN_APPROACH];
            end
            HM_DOG_ONLY: begin
                creep_hit = rise[SN_APPROACH];
                creep_ok = 1'b1;
            end
            HM_LIMIT_MARKER: begin
                creep_hit = marker_ev && at_speed;
                creep_ok = 1'b1;
            end
            HM_LIMIT_ONLY: begin
                creep_hit = back_fall;
                creep_ok = 1'b1;
            end
            default: begin
                creep_hit = 1'b0;
                creep_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Speed selection for the ramp
    // ------------------------------------------------------------------
    always_comb begin
        rcmd.acc_ms = rc_acc;
        rcmd.dec_ms = rc_dec;
        unique case (state)
            S_SEEK: rcmd.target = cfg.home_high;
            S_CREEP, S_COMP: rcmd.target = cfg.home_low;
            S_JOG: rcmd.target = jog_fast ? cfg.jog_high
                                          : cfg.jog_low;
            S_INCH: rcmd.target = cfg.inch_speed;
            default: rcmd.target = '0;
        endcase
    end

    motion_ramp #(
        .MS_CYCLES(MS_CYCLES)
    ) u_ramp (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .cmd(rcmd),
        .halt(halt),
        .step(step_pulse),
        .speed(speed),
        .at_speed(at_speed),
        .stopped(stopped)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= S_IDLE;
            after <= AF_IDLE;
            dir <= COUNTER_CLOCKWISE_DIRECTION;
            reversed <= 1'b0;
            dog_hits <= 1'b0;
            jog_fast <= 1'b0;
            halt <= 1'b0;
            homed <= 1'b0;
            home_error <= 1'b0;
            pos_done <= 1'b0;
            cmd_rejected <= 1'b0;
            remain <= 32'h0000_0000;
            rc_acc <= 16'h0000;
            rc_dec <= 16'h0000;
        end else if (ce) begin
            halt <= 1'b0;
            cmd_rejected <= (state != S_IDLE) && any_start;
            unique case (state)
                S_IDLE: begin
                    if (home_start) begin
                        state <= S_SEEK;
                        dir <= cfg.home_dir;
                        rc_acc <= cfg.home_acc_ms;
                        rc_dec <= cfg.home_dec_ms;
                        reversed <= 1'b0;
                        dog_hits <= 1'b0;
                        homed <= 1'b0;
                        home_error <= 1'b0;
                        pos_done <= 1'b0;
                    end else if (jog_start) begin
                        state <= S_JOG;
                        dir <= jog_dir;
                        jog_fast <= jog_high_sel;
                        rc_acc <= cfg.jog_acc_ms;
                        rc_dec <= cfg.jog_dec_ms;
                        pos_done <= 1'b0;
                    end else if (inch_start) begin
                        state <= (inch_distance == '0) ? S_DWELL : S_INCH;
                        dir <= inch_dir;
                        remain <= inch_distance;
                        rc_acc <= cfg.jog_acc_ms;
                        rc_dec <= cfg.jog_dec_ms;
                        pos_done <= 1'b0;
                    end
                end
                S_SEEK: begin
                    if (ahead_limit) begin
                        halt <= 1'b1;
                        state <= S_STOP;
                        reversed <= 1'b1;
                        after <= limit_method ? AF_REV_SLOW
                                              : AF_REV_FAST;
                    end else if (rise[SN_APPROACH] && !limit_method) begin
                        if (cfg.method == HM_DOG_ONLY) begin
                            state <= S_STOP;
                            after <= dog_hits ? AF_REV_SLOW : AF_REV_FAST;
                            dog_hits <= 1'b1;
                        end else if (reversed) begin
                            state <= S_STOP;
                            after <= AF_REV_FAST;
                            reversed <= 1'b0;
                        end else begin
                            state <= S_CREEP;
                        end
                    end
                end
                S_CREEP: begin
                    if (ahead_limit) begin
                        halt <= 1'b1;
                        state <= S_STOP;
                        after <= AF_ERROR;
                    end else if (creep_hit) begin
                        halt <= 1'b1;
                        state <= S_STOP;
                        after <= creep_ok ? AF_HOME : AF_ERROR;
                    end
                end
                S_COMP, S_INCH: begin
                    if (state == S_INCH && ahead_limit) begin
                        halt <= 1'b1;
                        state <= S_STOP;
                        after <= AF_DONE;
                    end else if (step_pulse) begin
                        remain <= remain - 1'b1;
                        if (remain == 32'h0000_0001) begin
                            halt <= 1'b1;
                            state <= S_STOP;
                            after <= (state == S_COMP) ? AF_SET : AF_DONE;
                        end
                    end
                end
                S_JOG: begin
                    if (ahead_limit) begin
                        halt <= 1'b1;
                        state <= S_STOP;
                        after <= AF_IDLE;
                    end else if (jog_stop) begin
                        state <= S_STOP;
                        after <= AF_IDLE;
                    end
                end
                S_STOP: begin
                    if (stopped) begin
                        unique case (after)
                            AF_REV_FAST: begin
                                dir <= ~dir;
                                state <= S_SEEK;
                            end
                            AF_REV_SLOW: begin
                                dir <= ~dir;
                                state <= S_CREEP;
                            end
                            AF_HOME: begin
                                if (cfg.home_comp != 0) begin
                                    state <= S_COMP;
                                    remain <= magnitude(cfg.home_comp);
                                    dir <= cfg.home_comp[31];
                                end else begin
                                    homed <= 1'b1;
                                    state <= S_DWELL;
                                end
                            end
                            AF_SET: begin
                                homed <= 1'b1;
                                state <= S_DWELL;
                            end
                            AF_ERROR: begin
                                home_error <= 1'b1;
                                state <= S_IDLE;
                            end
                            AF_DONE: state <= S_DWELL;
                            AF_IDLE: state <= S_IDLE;
                        endcase
                    end
                end
                S_DWELL: begin
                    if (dwell_cnt >= dwell_target) begin
                        pos_done <= 1'b1;
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Dwell timer
    // ------------------------------------------------------------------
    assign dwell_target = 32'(cfg.dwell_ms) * 32'(MS_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dwell_cnt <= 32'h0000_0000;
        end else if (ce) begin
            if (state == S_DWELL) begin
                dwell_cnt <= dwell_cnt + 1'b1;
            end else begin
                dwell_cnt <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Current position
    // ------------------------------------------------------------------
    // Pulses made while homing are not counted.
    assign home_load = (state == S_STOP) && stopped &&
                       ((after == AF_SET) ||
                        (after == AF_HOME && cfg.home_comp == 0));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            position <= 32'sh0000_0000;
        end else if (ce) begin
            if (home_load) begin
                position <= cfg.home_addr;
            end else if (step_pulse && homed) begin
                if (dir == COUNTER_CLOCKWISE_DIRECTION) begin
                    position <= position - 32'sh0000_0001;
                end else begin
                    position <= position + 32'sh0000_0001;
                end
            end
        end
    end

    assign step_dir = dir;
    assign status.busy = (state != S_IDLE);
    assign status.homed = homed;
    assign status.home_error = home_error;
    assign status.pos_done = pos_done;
    assign status.cmd_rejected = cmd_rejected;

endmodule

// *** verification/axis_seq_chk.sv ***
// Assertions on the sequencer's ports.
`timescale 1ns/10ps
module axis_seq_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire axis_pkg::axis_cfg_t cfg,
    input wire logic home_start,
    input wire logic jog_start,
    input wire logic inch_start,
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic signed [31:0] position,
    input wire axis_pkg::axis_status_t status
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_start;
        home_start || jog_start || inch_start;
    endsequence
    sequence s_keep_dir;
        $stable(step_dir) [*2];
    endsequence
    property p_accept;
        s_start ##0 !status.busy |=> status.busy && !status.pos_done;
    endproperty
    a_accept: assert property (p_accept)
        else $error("start lost");
    property p_reject;
        s_start ##0 status.busy |=> status.cmd_rejected;
    endproperty
    a_reject: assert property (p_reject)
        else $error("no reject");
    property p_clear;
        home_start && !status.busy |=> !status.homed && !status.home_error;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flags kept");
    property p_load;
        $rose(status.homed) |-> position == cfg.home_addr;
    endproperty
    a_load: assert property (p_load)
        else $error("no load");
    property p_hold;
        !status.homed ##1 !status.homed |-> $stable(position);
    endproperty
    a_hold: assert property (p_hold)
        else $error("moved unhomed");
    property p_count;
        status.homed && step_pulse |=> position ==
            $past(position) + ($past(step_dir) ? -32'sd1 : 32'sd1);
    endproperty
    a_count: assert property (p_count)
        else $error("bad count");
    property p_done;
        $rose(status.pos_done) |->
            !status.busy && !$past(step_pulse) && !$past(step_pulse, 2);
    endproperty
    a_done: assert property (p_done)
        else $error("early done");
    property p_dir;
        step_pulse |=> s_keep_dir;
    endproperty
    a_dir: assert property (p_dir)
        else $error("dir flip");
endmodule

// *** verification/axis_drive_model.sv ***
// Drive and sensor model: follows the pulses and drives the axis sensors.
`timescale 1ns/10ps
module axis_drive_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic step_pulse,
    input wire logic step_dir,
    output logic signed [31:0] phys,
    output logic approach,
    output logic marker,
    output logic upper_limit,
    output logic lower_limit
);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phys <= '0;
        end else if (step_pulse) begin
            phys <= step_dir ? phys - 32'sd1 : phys + 32'sd1;
        end
    end
    assign approach = (phys >= -20) && (phys <= -12);
    assign marker = (phys >= -25) && (phys <= -23);
    assign upper_limit = (phys >= 16);
    assign lower_limit = (phys <= -40);
endmodule

// *** verification/axis_homing_jog_sequencer_tb_top.sv ***
// Bench for the axis sequencer.
`timescale 1ns/10ps
module axis_homing_jog_sequencer_tb_top;
    import axis_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic home_start = 1'b0, jog_start = 1'b0, jog_stop = 1'b0;
    logic jog_high_sel = 1'b0, jog_dir = 1'b0;
    logic inch_start = 1'b0, inch_dir = 1'b0, first_dir;
    logic [31:0] inch_distance = 32'h0, p0;
    axis_cfg_t cfg = CFG_DEFAULT;
    logic approach, marker, upper_limit, lower_limit, step_pulse, step_dir;
    logic signed [31:0] position, phys;
    axis_status_t status;
    int num_errors = 0, n_checks = 0, nsteps = 0, cyc = 0, last_step = 0;
    axis_homing_jog_sequencer #(.MS_CYCLES(10)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .cfg(cfg),
        .home_start(home_start), .jog_start(jog_start),
        .jog_high_sel(jog_high_sel), .jog_dir(jog_dir), .jog_stop(jog_stop),
        .inch_start(inch_start), .inch_dir(inch_dir),
        .inch_distance(inch_distance), .approach(approach), .marker(marker),
        .enc_index(1'b0), .upper_limit(upper_limit),
        .lower_limit(lower_limit), .step_pulse(step_pulse),
        .step_dir(step_dir), .position(position), .status(status));
    axis_drive_model u_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .step_pulse(step_pulse), .step_dir(step_dir), .phys(phys),
        .approach(approach), .marker(marker), .upper_limit(upper_limit),
        .lower_limit(lower_limit));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (step_pulse === 1'b1) begin
            if (nsteps == 0) first_dir <= step_dir;
            nsteps <= nsteps + 1;
            last_step <= cyc;
        end
    end
    function automatic logic [31:0] moved(input logic [31:0] p, input int n,
                                          input logic d);
        return d ? p - 32'(n) : p + 32'(n);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Pulses one start: 0 home, 1 jog, 2 jog stop, 3 inching.
    task automatic go(input int k);
        if (k != 2) begin
            nsteps = 0;
            p0 = position;
        end
        {home_start, jog_start, jog_stop, inch_start} = 4'h8 >> k;
        tick(1);
        {home_start, jog_start, jog_stop, inch_start} = 4'h0;
    endtask
    task automatic idle();
        repeat (40000) begin
            if (status.busy === 1'b0) return;
            tick(1);
        end
        num_errors++;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(80000 * 100);
        num_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h8b89));
        {cfg.home_high, cfg.jog_high} = {2{20'h0c350}};
        {cfg.home_low, cfg.inch_speed, cfg.jog_low} = 60'h061a8_061a8_02710;
        {cfg.home_acc_ms, cfg.home_dec_ms, cfg.jog_acc_ms,
         cfg.jog_dec_ms} = {4{16'h0001}};
        cfg.home_addr = $urandom;
        tick(3);
        rst_n = 1'b1;
        cmp("status", 0, 32'(status));
        inch_distance = 32'(1 + $urandom % 6);
        inch_dir = 1'($urandom);
        go(3);
        go(0);
        cmp("rejected", 1, status.cmd_rejected);
        idle();
        cmp("steps", inch_distance, nsteps);
        cmp("position", 0, position);
        cmp("done", 1, status.pos_done);
        go(0);
        idle();
        cmp("dir", 1, first_dir);
        cmp("homed", 1, status.homed);
        cmp("position", cfg.home_addr, position);
        cmp("stop", 1, phys <= -23 && phys >= -25);
        for (int i = 0; i < 2; i++) begin
            jog_high_sel = 1'(1 - i);
            jog_dir = 1'(i);
            go(1);
            tick(1500);
            go(2);
            idle();
            cmp("jog speed", jog_high_sel, nsteps > 3);
            cmp("jog pos", moved(p0, nsteps, jog_dir), position);
        end
        cfg.dwell_ms = 16'h0002;
        go(3);
        idle();
        cmp("inch", moved(p0, inch_distance, inch_dir), position);
        cmp("dwell", 1, cyc - last_step >= 20);
        cfg.method = HM_LIMIT_ONLY;
        cfg.home_comp = 32'sh0000_0003;
        go(0);
        idle();
        cmp("phys", -36, phys);
        cmp("position", cfg.home_addr, position);
        cfg.method = HM_DOG_HELD;
        cfg.home_dir = CLOCKWISE_DIRECTION;
        go(0);
        idle();
        cmp("error", 2'h1, {status.homed, status.home_error});
        complete_run();
    end
endmodule
bind axis_homing_jog_sequencer axis_seq_chk u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .cfg(cfg), .home_start(home_start),
    .jog_start(jog_start), .inch_start(inch_start), .step_pulse(step_pulse),
    .step_dir(step_dir), .position(position), .status(status));
